// *** verilog/icr_slave.sv ***
// icr_slave: two-wire slave port over a 256 byte configuration space
// assumes: scl and sda arrive asynchronously from an external master;
// the wire level is resolved outside from the output enables
`timescale 1ns/10ps
// Notes on behaviour
// RULE1 - only seven bit device addresses decoded
// RULE2 - address fixed high bits, low two strapped
// RULE3 - strap bits sampled at reset release
// RULE4 - slave may hold clock low; master waits
// RULE5 - general call 0x06 performs software reset
// RULE6 - general call 0x04 reloads strapped address
// RULE7 - any rate to 1 Mbit/s, no setup
// RULE8 - 256 byte locations addressed 0x00 to 0xff
// RULE9 - upper page backed by nonvolatile store
// RULE10 - wide registers stored msb first
// RULE11 - control page returns to defaults on reset
// RULE12 - upper page reloaded from store on reset
// RULE13 - 128 byte nonvolatile store present
// RULE14 - serial port is sole configuration path
// RULE15 - host downloads sequencer after every power-up
// RULE16 - software reset equals hardware reset
// RULE17 - writes auto-increment pointer per data byte
// RULE18 - reads auto-increment until master nacks
// RULE19 - reload takes bits 2 to 6 of 0xca; code takes them from the register at regPtr
// RULE20 - acknowledge own and general call only
// RULE21 - host writes change volatile copy only
module icr_slave (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // address straps
   input wire logic strap_addr_bit_low,
   input wire logic strap_addr_bit_high,
   // two-wire bus, output enable low while driving low
   input wire logic sclIn,
   output logic sclOe_n,
   input wire logic sdaIn,
   output logic sdaOe_n,
   // nonvolatile store programming
   input wire logic nvmWrEn,
   input wire logic [6:0] nvmAddr,
   input wire logic [7:0] nvmData,
   // current device address
   output logic [6:0] devAddr
);
   // ***************************************************
   // reset and input synchronisers
   // ***************************************************
   logic [1:0] rstPipe;
   logic rstSync_n;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rstPipe <= 2'b00;
      end else begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign rstSync_n = rstPipe[1];
   // first stage feeds only the second stage
   logic [1:0] syncA, syncB, strapA, strapB;
   logic scl, sda, sclPrev, sdaPrev;
   always_ff @(posedge clk_sys or negedge rstSync_n) begin
      if (!rstSync_n) begin
         syncA <= 2'b11;
         syncB <= 2'b11;
      end else begin
         syncA <= {sdaIn, sclIn};
         syncB <= syncA;
      end
   end
   // straps sample through reset, so the capture sees pins, not reset values
   always_ff @(posedge clk_sys) begin
      strapA <= {strap_addr_bit_high, strap_addr_bit_low};
      strapB <= strapA;
   end
   assign scl = syncB[0];
   assign sda = syncB[1];
   // engine state and its next values
   icr_pkg::icr_state_t state, next_state;
   logic [7:0] shiftReg, next_shiftReg;
   logic [2:0] bitCnt, next_bitCnt;
   logic [7:0] regPtr, next_regPtr;
   logic [1:0] byteIdx, next_byteIdx; // 0 device addr, 1 reg addr, 2 data
   logic isRead, next_isRead;
   logic isGc, next_isGc;
   logic ackDrive, next_ackDrive;
   logic sdaHold_n, next_sdaHold_n;
   logic sclHold_n, next_sclHold_n;
   logic [1:0] stretch, next_stretch;
   logic [1:0] strapCap, next_strapCap;
   logic strapDone, next_strapDone;
   logic [6:0] addrReg, next_addrReg;
   logic softReset, next_softReset;
   logic wrEn, next_wrEn;
   logic [7:0] wrData, next_wrData;
   logic [7:0] wrAddr, next_wrAddr;
   logic [7:0] rdData;
   logic loading;
   // register space, control page and upper page [RULE14]
   icr_regmem u_mem (
      .clk_sys(clk_sys),
      .rstSync_n(rstSync_n),
      .softReset(softReset),
      .wrEn(wrEn),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .rdAddr(regPtr),
      .rdData(rdData),
      .nvmWrEn(nvmWrEn),
      .nvmAddr(nvmAddr),
      .nvmData(nvmData),
      .loading(loading)
   );
   logic sclRise, sclFall, startCond, stopCond;
   assign sclRise = scl && !sclPrev;
   assign sclFall = !scl && sclPrev;
   assign startCond = scl && sclPrev && sdaPrev && !sda;
   assign stopCond = scl && sclPrev && !sdaPrev && sda;
   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      next_state = state;
      next_shiftReg = shiftReg;
      next_bitCnt = bitCnt;
      next_regPtr = regPtr;
      next_byteIdx = byteIdx;
      next_isRead = isRead;
      next_isGc = isGc;
      next_ackDrive = ackDrive;
      next_sdaHold_n = sdaHold_n;
      next_sclHold_n = sclHold_n;
      next_stretch = stretch;
      next_strapCap = strapCap;
      next_strapDone = 1'b1;
      next_addrReg = addrReg;
      next_softReset = 1'b0;
      next_wrEn = 1'b0;
      next_wrData = wrData;
      next_wrAddr = wrAddr;
      // straps caught once after reset release [RULE3]
      if (!strapDone) begin
         next_strapCap = strapB;
         next_addrReg = {icr_pkg::ADDR_FIXED_HI, strapB}; // [RULE2]
      end
      // stretch: hold scl low a few cycles while data settles [RULE4]
      if (stretch != 2'b00) begin
         next_stretch = stretch - 2'b01;
      end else begin
         next_sclHold_n = !loading; // any reset's reload holds scl low
      end
      if (startCond) begin
         next_state = icr_pkg::ST_ADDR;
         next_bitCnt = 3'h0;
         next_byteIdx = 2'h0;
         next_sdaHold_n = 1'b1;
      end else if (stopCond) begin
         next_state = icr_pkg::ST_IDLE;
         next_sdaHold_n = 1'b1;
      end else begin
         case (state)
            icr_pkg::ST_ADDR, icr_pkg::ST_RXB: begin
               if (sclRise) begin
                  next_shiftReg = {shiftReg[6:0], sda};
                  next_bitCnt = bitCnt + 3'h1;
                  if (bitCnt == 3'h7) begin
                     next_state = icr_pkg::ST_ACK;
                     next_ackDrive = 1'b0;
                  end
               end
            end
            icr_pkg::ST_ACK: begin
               if (sclFall && !ackDrive) begin
                  next_ackDrive = 1'b1;
                  next_stretch = icr_pkg::STRETCH_LOAD;
                  next_sclHold_n = 1'b0;
                  if (state == icr_pkg::ST_ACK && byteIdx == 2'h0) begin
                     // seven bit address only [RULE1] [RULE20]
                     if (shiftReg[7:1] == addrReg) begin
                        next_sdaHold_n = 1'b0;
                        next_isRead = shiftReg[0];
                        next_isGc = 1'b0;
                     end else if (shiftReg == icr_pkg::GC_ADDR) begin
                        next_sdaHold_n = 1'b0;
                        next_isRead = 1'b0;
                        next_isGc = 1'b1;
                     end else begin
                        next_state = icr_pkg::ST_IDLE;
                        next_sclHold_n = 1'b1;
                        next_stretch = 2'b00;
                     end
                  end else if (isGc) begin
                     next_sdaHold_n = 1'b0;
                     if (shiftReg == icr_pkg::GC_SW_RESET) begin
                        next_softReset = 1'b1; // [RULE5] [RULE16]
                        next_addrReg = {icr_pkg::ADDR_FIXED_HI, strapCap};
                     end else if (shiftReg == icr_pkg::GC_ADDR_RELOAD) begin
                        // programmable bits from the register at regPtr, straps kept [RULE6]
                        next_addrReg = {
                           rdData[icr_pkg::DEV_ADDR_HI_POS:
                                  icr_pkg::DEV_ADDR_LO_POS], strapCap}; // [RULE19]
                     end
                  end else begin
                     next_sdaHold_n = 1'b0;
                     if (byteIdx == 2'h1) begin
                        next_regPtr = shiftReg;
                     end else begin
                        next_wrEn = 1'b1;
                        next_wrAddr = regPtr;
                        next_wrData = shiftReg; // msb byte at lower addr [RULE10]
                        next_regPtr = regPtr + 8'h01; // [RULE17]
                     end
                  end
               end else if (sclFall && ackDrive) begin
                  // end of ack bit: release sda or start sending
                  next_sdaHold_n = 1'b1;
                  next_bitCnt = 3'h0;
                  if (byteIdx != 2'h2) begin
                     next_byteIdx = byteIdx + 2'h1;
                  end
                  if (isRead && byteIdx == 2'h0) begin
                     next_state = icr_pkg::ST_TXB;
                     next_shiftReg = rdData;
                     next_sdaHold_n = rdData[7];
                     next_regPtr = regPtr + 8'h01;
                  end else begin
                     next_state = icr_pkg::ST_RXB;
                  end
               end
            end
            icr_pkg::ST_TXB: begin
               if (sclFall) begin
                  next_bitCnt = bitCnt + 3'h1;
                  if (bitCnt == 3'h7) begin
                     next_state = icr_pkg::ST_RACK;
                     next_sdaHold_n = 1'b1;
                  end else begin
                     next_shiftReg = {shiftReg[6:0], 1'b0};
                     next_sdaHold_n = shiftReg[6];
                  end
               end
            end
            icr_pkg::ST_RACK: begin
               if (sclRise) begin
                  next_ackDrive = sda; // high means master nack
               end else if (sclFall) begin
                  if (ackDrive) begin
                     next_state = icr_pkg::ST_IDLE; // nack ends read [RULE18]
                  end else begin
                     next_state = icr_pkg::ST_TXB;
                     next_bitCnt = 3'h0;
                     next_shiftReg = rdData;
                     next_sdaHold_n = rdData[7];
                     next_regPtr = regPtr + 8'h01; // [RULE18]
                     next_stretch = icr_pkg::STRETCH_LOAD;
                     next_sclHold_n = 1'b0;
                  end
               end
            end
            default: begin
               next_state = icr_pkg::ST_IDLE;
               next_sdaHold_n = 1'b1;
            end
         endcase
      end
   end
   // ***************************************************
   // registers; edge detection tolerates scl rates to 1 Mbit/s [RULE7]
   // ***************************************************
   always_ff @(posedge clk_sys or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state <= icr_pkg::ST_IDLE;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
         shiftReg <= 8'h00;
         bitCnt <= 3'h0;
         regPtr <= 8'h00;
         byteIdx <= 2'h0;
         isRead <= 1'b0;
         isGc <= 1'b0;
         ackDrive <= 1'b0;
         sdaHold_n <= 1'b1;
         sclHold_n <= 1'b1;
         stretch <= 2'b00;
         strapCap <= 2'b00;
         strapDone <= 1'b0;
         addrReg <= {icr_pkg::ADDR_FIXED_HI, 2'b00};
         softReset <= 1'b0;
         wrEn <= 1'b0;
         wrData <= 8'h00;
         wrAddr <= 8'h00;
      end else begin
         state <= next_state;
         sclPrev <= scl;
         sdaPrev <= sda;
         shiftReg <= next_shiftReg;
         bitCnt <= next_bitCnt;
         regPtr <= next_regPtr;
         byteIdx <= next_byteIdx;
         isRead <= next_isRead;
         isGc <= next_isGc;
         ackDrive <= next_ackDrive;
         sdaHold_n <= next_sdaHold_n;
         sclHold_n <= next_sclHold_n;
         stretch <= next_stretch;
         strapCap <= next_strapCap;
         strapDone <= next_strapDone;
         addrReg <= next_addrReg;
         softReset <= next_softReset;
         wrEn <= next_wrEn;
         wrData <= next_wrData;
         wrAddr <= next_wrAddr;
      end
   end
   // outputs straight from flip-flops
   assign sdaOe_n = sdaHold_n;
   assign sclOe_n = sclHold_n;
   assign devAddr = addrReg;
endmodule

// *** verilog/icr_pkg.sv ***
// icr_pkg: constants for the two-wire configuration register slave
// assumes: used by icr_slave and icr_regmem, referenced with icr_pkg::
package icr_pkg;
   // ***************************************************
   // device addressing
   // ***************************************************
   localparam logic [4:0] ADDR_FIXED_HI = 5'h08; // upper five address bits
   localparam logic [7:0] GC_ADDR = 8'h00;
   localparam logic [7:0] GC_SW_RESET = 8'h06;
   localparam logic [7:0] GC_ADDR_RELOAD = 8'h04;
   localparam logic [7:0] REG_DEV_ADDR = 8'hca;
   localparam int DEV_ADDR_LO_POS = 2;
   localparam int DEV_ADDR_HI_POS = 6;
   // ***************************************************
   // memory map
   // ***************************************************
   localparam int REG_COUNT = 256;
   localparam int NVM_COUNT = 128;
   localparam logic [7:0] UPPER_PAGE_BASE = 8'h80;
   localparam logic [7:0] CTRL_DEFAULT = 8'h00;
   localparam logic [7:0] NVM_ERASED = 8'hff;
   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLK_MHZ = 10;
   localparam int STRETCH_NS = 300; // ack/data setup hold-off, least time
   localparam int STRETCH_CYC =
      (STRETCH_NS * CLK_MHZ + 999) / 1000;
   localparam logic [1:0] STRETCH_LOAD = 2'(STRETCH_CYC);
   // ***************************************************
   // port state machine, one-hot
   // ***************************************************
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_RXB = 6'h04,
      ST_TXB = 6'h08,
      ST_ACK = 6'h10,
      ST_RACK = 6'h20
   } icr_state_t;
endpackage

// *** verilog/icr_regmem.sv ***
// icr_regmem: 256 byte register space with 128 byte nonvolatile store
// assumes: one write port from the serial engine, reads are combinational
`timescale 1ns/10ps
module icr_regmem (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstSync_n,
   input wire logic softReset,
   // access from the serial engine
   input wire logic wrEn,
   input wire logic [7:0] wrAddr,
   input wire logic [7:0] wrData,
   input wire logic [7:0] rdAddr,
   output logic [7:0] rdData,
   // nonvolatile store programming
   input wire logic nvmWrEn,
   input wire logic [6:0] nvmAddr,
   input wire logic [7:0] nvmData,
   // reload in progress
   output logic loading
);
   // ***************************************************
   // storage
   // ***************************************************
   logic [7:0] regs [0:icr_pkg::REG_COUNT-1];
   logic [7:0] nvm [0:icr_pkg::NVM_COUNT-1];
   logic [7:0] loadIdx;
   logic [7:0] next_loadIdx;
   logic loadBusy;
   logic next_loadBusy;
   // reload walks the upper page one byte per cycle after any reset
   always_comb begin
      next_loadIdx = loadIdx;
      next_loadBusy = loadBusy;
      if (softReset) begin
         next_loadIdx = 8'h00;
         next_loadBusy = 1'b1;
      end else if (loadBusy) begin
         next_loadIdx = loadIdx + 8'h01;
         if (loadIdx == 8'(icr_pkg::NVM_COUNT - 1)) begin
            next_loadBusy = 1'b0;
         end
      end
   end
   always_ff @(posedge clk_sys or negedge rstSync_n) begin
      if (!rstSync_n) begin
         loadIdx <= 8'h00;
         loadBusy <= 1'b1;
      end else begin
         loadIdx <= next_loadIdx;
         loadBusy <= next_loadBusy;
      end
   end
   // control page defaults, upper page copied from the store [RULE11]
   // [RULE12] [RULE9] memories have no reset so the array stays RAM-like
   always_ff @(posedge clk_sys) begin
      if (softReset) begin
         for (int i = 0; i < icr_pkg::NVM_COUNT; i++) begin
            regs[i] <= icr_pkg::CTRL_DEFAULT;
         end
      end else if (loadBusy) begin
         regs[{1'b1, loadIdx[6:0]}] <= nvm[loadIdx[6:0]];
         if (loadIdx == 8'h00) begin
            for (int i = 0; i < icr_pkg::NVM_COUNT; i++) begin
               regs[i] <= icr_pkg::CTRL_DEFAULT;
            end
         end
      end else if (wrEn) begin
         regs[wrAddr] <= wrData; // host write touches the copy only [RULE21]
      end
   end
   // the store changes only through its programming access [RULE13]
   always_ff @(posedge clk_sys) begin
      if (nvmWrEn) begin
         nvm[nvmAddr] <= nvmData;
      end
   end
   assign rdData = regs[rdAddr]; // [RULE8]
   assign loading = loadBusy;
endmodule

// *** sim/icr_slave_chk.sv ***
// icr_slave_chk: bus timing and address assertions for the slave port
// assumes: straps change only while reset_n is low
`timescale 1ns/10ps
module icr_slave_chk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // straps and two-wire bus
   input wire logic strap_addr_bit_low,
   input wire logic strap_addr_bit_high,
   input wire logic sclIn,
   input wire logic sclOe_n,
   input wire logic sdaIn,
   input wire logic sdaOe_n,
   // store port and address
   input wire logic nvmWrEn,
   input wire logic [6:0] nvmAddr,
   input wire logic [7:0] nvmData,
   input wire logic [6:0] devAddr
);
   // ***************************************************
   // helper counters
   // ***************************************************
   logic [3:0] relCnt, next_relCnt;
   logic [7:0] idleCnt, next_idleCnt;
   logic [7:0] lowCnt, next_lowCnt;
   // saturating: time since reset, idle bus time, stretch length
   always_comb begin
      next_relCnt = (relCnt == 4'hf) ? relCnt : relCnt + 4'h1;
      next_idleCnt = !(sclIn && sdaIn) ? 8'h00 :
         (idleCnt == 8'hff) ? idleCnt : idleCnt + 8'h01;
      next_lowCnt = sclOe_n ? 8'h00 :
         (lowCnt == 8'hff) ? lowCnt : lowCnt + 8'h01;
   end
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         relCnt <= 4'h0;
         idleCnt <= 8'h00;
         lowCnt <= 8'h00;
      end else begin
         relCnt <= next_relCnt;
         idleCnt <= next_idleCnt;
         lowCnt <= next_lowCnt;
      end
   end
   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // reload holds the clock well over ninety cycles, then frees it
   sequence s_held;
      ##[100:120] (lowCnt >= 8'h60);
   endsequence
   sequence s_freed;
      ##[1:200] sclOe_n;
   endsequence
   property p_reload;
      $rose(reset_n) |-> s_held ##0 s_freed;
   endproperty
   a_reload: assert property (p_reload) else $error("no reload hold");
   property p_addr_fix;
      $rose(reset_n) |-> (devAddr[6:2] == icr_pkg::ADDR_FIXED_HI)[*3];
   endproperty
   a_addr_fix: assert property (p_addr_fix) else $error("addr high");
   property p_strap;
      relCnt == 4'hf |->
         devAddr[1:0] == {strap_addr_bit_high, strap_addr_bit_low};
   endproperty
   a_strap: assert property (p_strap) else $error("strap bits");
   property p_sda_chg;
      $changed(sdaOe_n) |-> !$past(sclIn);
   endproperty
   a_sda_chg: assert property (p_sda_chg) else $error("sda moved");
   property p_ack_gap;
      $fell(sdaOe_n) |-> !$past(sclIn) && !$past(sclIn, 2);
   endproperty
   a_ack_gap: assert property (p_ack_gap) else $error("sda early");
   property p_stretch;
      lowCnt < 8'd200;
   endproperty
   a_stretch: assert property (p_stretch) else $error("long stretch");
   property p_idle_addr;
      idleCnt == 8'hff |-> $stable(devAddr);
   endproperty
   a_idle_addr: assert property (p_idle_addr) else $error("addr drift");
   property p_rst_sda;
      $rose(reset_n) |-> sdaOe_n [*8];
   endproperty
   a_rst_sda: assert property (p_rst_sda) else $error("sda at reset");
endmodule
bind icr_slave icr_slave_chk u_icr_slave_chk (
   .clk_sys(clk_sys),
   .reset_n(reset_n),
   .strap_addr_bit_low(strap_addr_bit_low),
   .strap_addr_bit_high(strap_addr_bit_high),
   .sclIn(sclIn),
   .sclOe_n(sclOe_n),
   .sdaIn(sdaIn),
   .sdaOe_n(sdaOe_n),
   .nvmWrEn(nvmWrEn),
   .nvmAddr(nvmAddr),
   .nvmData(nvmData),
   .devAddr(devAddr)
);

// *** sim/icr_master.sv ***
// icr_master: behavioural two-wire bus master, 800 ns bit period
// assumes: bench resolves the open-drain wires, pull-ups on both
`timescale 1ns/10ps
module icr_master (
   // clock
   input wire logic clk_sys,
   // resolved wire levels
   input wire logic sclWire,
   input wire logic sdaWire,
   // master drive, 0 pulls the wire low
   output logic sclDrv,
   output logic sdaDrv,
   // byte seen: ack flag after writes, data after reads
   output logic [7:0] rxByte,
   output logic rxStrobe
);
   // bus idles released; the clock stands still between frames
   initial begin
      sclDrv = 1'b1;
      sdaDrv = 1'b1;
      rxByte = 8'h00;
      rxStrobe = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // release scl, wait while the slave stretches it
   task automatic rise();
      sclDrv = 1'b1;
      #1;
      for (int k = 0; k < 300 && sclWire !== 1'b1; k++) begin
         @(negedge clk_sys);
      end
   endtask
   // start or stop: sda moves while scl high
   task automatic cond(input logic isStart);
      tick(2);
      sdaDrv = isStart;
      tick(3);
      rise();
      tick(3);
      sdaDrv = !isStart;
      tick(3);
      if (isStart) begin
         sclDrv = 1'b0;
      end
   endtask
   // low 5 cycles, high 3: no rate setup needed by the slave
   task automatic bitX(input logic b, output logic s);
      tick(2);
      sdaDrv = b;
      tick(3);
      rise();
      tick(2);
      s = sdaWire;
      tick(1);
      sclDrv = 1'b0;
   endtask
   task automatic post(input logic [7:0] v);
      rxByte = v;
      rxStrobe = 1'b1;
      tick(1);
      rxStrobe = 1'b0;
   endtask
   // byte out msb first, then the slave's ack bit
   task automatic wrByte(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bitX(d[i], s);
      bitX(1'b1, s);
      post({7'h00, !s});
   endtask
   // byte in, then ack to continue or nack to end
   task automatic rdByte(input logic ackIt);
      logic [7:0] d;
      logic s;
      for (int i = 7; i >= 0; i--) bitX(1'b1, d[i]);
      bitX(!ackIt, s);
      post(d);
   endtask
endmodule

// *** sim/icr_slave_tb_top.sv ***
// icr_slave_tb_top: self-checking bench for the two-wire slave port
// assumes: icr_master on the bus, checker bound into icr_slave
`timescale 1ns/10ps
module icr_slave_tb_top;
   logic clk_sys = 1'b0;
   logic reset_n, strapLo, strapHi, nvmWrEn;
   logic [6:0] nvmAddr;
   logic [7:0] nvmData;
   logic sclOe_n, sdaOe_n, sclDrv, sdaDrv, sclWire, sdaWire, rxStrobe;
   logic [7:0] rxByte;
   logic [6:0] devAddr, devA, oldA;
   logic [7:0] dat [8];
   logic [7:0] nv [5];
   logic [7:0] expQ [$];
   string nameQ [$];
   int num_errors = 0;
   int comparisons = 0;
   // open-drain wires with pull-ups
   assign sclWire = sclDrv & sclOe_n;
   assign sdaWire = sdaDrv & sdaOe_n;
   icr_slave u_icr_slave (.clk_sys(clk_sys), .reset_n(reset_n),
      .strap_addr_bit_low(strapLo), .strap_addr_bit_high(strapHi),
      .sclIn(sclWire), .sclOe_n(sclOe_n), .sdaIn(sdaWire),
      .sdaOe_n(sdaOe_n), .nvmWrEn(nvmWrEn), .nvmAddr(nvmAddr),
      .nvmData(nvmData), .devAddr(devAddr));
   icr_master u_icr_master (.clk_sys(clk_sys), .sclWire(sclWire),
      .sdaWire(sdaWire), .sclDrv(sclDrv), .sdaDrv(sdaDrv),
      .rxByte(rxByte), .rxStrobe(rxStrobe));
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   // ***************************************************
   // checking
   // ***************************************************
   task automatic stop_test();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      comparisons++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // each byte the master reports is matched to the oldest note
   always @(posedge clk_sys) begin
      if (rxStrobe === 1'b1) begin
         if (expQ.size() == 0) begin
            num_errors++;
            $display("ERROR rxByte expected none seen %h", rxByte);
         end else begin
            chk(nameQ.pop_front(), expQ.pop_front(), rxByte);
         end
      end
   end
   // a hang counts as a mismatch; normal run is near 13k cycles
   initial begin
      repeat (60000) @(posedge clk_sys);
      num_errors++;
      $display("ERROR watchdog expected end seen hang");
      stop_test();
   end
   // ***************************************************
   // bus sequences
   // ***************************************************
   task automatic sb(logic [7:0] b, logic ack);
      nameQ.push_back("ack");
      expQ.push_back({7'h00, ack});
      u_icr_master.wrByte(b);
   endtask
   task automatic rb(logic ackIt, logic [7:0] e);
      nameQ.push_back("rdata");
      expQ.push_back(e);
      u_icr_master.rdByte(ackIt);
   endtask
   // stop, then let the bus idle long enough for the address check
   task automatic fin();
      u_icr_master.cond(1'b0);
      repeat (260) @(negedge clk_sys);
   endtask
   task automatic probe(logic [7:0] b, logic ack);
      u_icr_master.cond(1'b1);
      sb(b, ack);
      fin();
   endtask
   task automatic wrSeq(logic [7:0] ra, int n);
      u_icr_master.cond(1'b1);
      sb({devA, 1'b0}, 1'b1);
      sb(ra, 1'b1);
      for (int i = 0; i < n; i++) sb(dat[i], 1'b1);
      fin();
   endtask
   task automatic rdSeq(logic [7:0] ra, int n);
      u_icr_master.cond(1'b1);
      sb({devA, 1'b0}, 1'b1);
      sb(ra, 1'b1);
      u_icr_master.cond(1'b1);
      sb({devA, 1'b1}, 1'b1);
      for (int i = 0; i < n; i++) rb(i != n - 1, dat[i]);
      fin();
   endtask
   task automatic gcall(logic [7:0] cmd);
      u_icr_master.cond(1'b1);
      sb(icr_pkg::GC_ADDR, 1'b1);
      sb(cmd, 1'b1);
      fin();
   endtask
   task automatic hwReset(logic lo, logic hi);
      @(negedge clk_sys);
      reset_n = 1'b0;
      strapLo = lo;
      strapHi = hi;
      repeat (5) @(negedge clk_sys);
      reset_n = 1'b1;
      repeat (200) @(negedge clk_sys);
      devA = {icr_pkg::ADDR_FIXED_HI, hi, lo};
      chk("devAddr", {1'b0, devA}, {1'b0, devAddr});
   endtask
   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      {reset_n, strapLo, strapHi, nvmWrEn, nvmAddr, nvmData} = '0;
      void'($urandom(32'h964dc033));
      hwReset(1'($urandom), 1'($urandom));
      probe({devA ^ 7'h04, 1'b0}, 1'b0);
      probe(8'hf0, 1'b0);
      for (int i = 0; i < 8; i++) dat[i] = 8'($urandom);
      wrSeq(8'h7e, 4);
      rdSeq(8'h7e, 4);
      wrSeq(8'hfe, 2);
      rdSeq(8'hfe, 2);
      // program the store; the volatile copies must not follow
      for (int i = 0; i < 5; i++) begin
         nv[i] = 8'($urandom);
         @(negedge clk_sys);
         nvmWrEn = 1'b1;
         nvmAddr = (i == 4) ? 7'h7f : 7'(i);
         nvmData = nv[i];
         @(negedge clk_sys);
         nvmWrEn = 1'b0;
      end
      for (int i = 0; i < 4; i++) dat[i] = ~nv[i];
      wrSeq(8'h80, 4);
      rdSeq(8'h80, 4);
      dat[0] = 8'($urandom) | 8'h01;
      wrSeq(8'h10, 1);
      hwReset(1'($urandom), 1'($urandom));
      dat[0] = icr_pkg::CTRL_DEFAULT;
      rdSeq(8'h10, 1);
      for (int i = 0; i < 4; i++) dat[i] = nv[i];
      rdSeq(8'h80, 4);
      dat[0] = nv[4];
      rdSeq(8'hff, 1);
      // software reset must undo host writes on both pages
      dat[0] = 8'($urandom) | 8'h01;
      wrSeq(8'h10, 1);
      dat[0] = ~nv[1];
      wrSeq(8'h81, 1);
      gcall(icr_pkg::GC_SW_RESET);
      dat[0] = icr_pkg::CTRL_DEFAULT;
      rdSeq(8'h10, 1);
      dat[0] = nv[1];
      rdSeq(8'h81, 1);
      // reload: high bits from register, low bits stay strapped
      dat[0] = {1'b0, 5'h0b, ~strapHi, ~strapLo};
      wrSeq(icr_pkg::REG_DEV_ADDR, 1);
      wrSeq(icr_pkg::REG_DEV_ADDR, 0);
      gcall(icr_pkg::GC_ADDR_RELOAD);
      oldA = devA;
      devA = {5'h0b, strapHi, strapLo};
      chk("devAddr", {1'b0, devA}, {1'b0, devAddr});
      probe({oldA, 1'b0}, 1'b0);
      rdSeq(icr_pkg::REG_DEV_ADDR, 1);
      stop_test();
   end
endmodule
